/* File: src/dlc_delay_calibrator.sv */
// Purpose: Per-region calibrator watching the reference clock.
// Assumes: Reference level arrives from another flop domain.
// Notes: Reset is asynchronous; release restarts the sequence.
`timescale 1ns/10ps
module dlc_delay_calibrator
  import dlc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cal_rst,
  input wire logic ref_lvl,
  output logic ready,
  output logic [7:0] trim
);

  typedef enum {CAL_RUN, CAL_DONE, CAL_LOST} dlc_cal_state_e;

  dlc_cal_state_e state_q;
  logic clr;
  logic ref_s1_q;
  logic ref_s2_q;
  logic ref_s3_q;
  logic ref_edge;
  logic [15:0] lat_q;
  logic [15:0] idle_q;

  assign clr = cal_rst | ~resetn;

  // ----------------------------------------------------------------
  // Reference sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge clr) begin
    if (clr) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end else begin
      ref_s1_q <= ref_lvl;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end
  assign ref_edge = ref_s2_q ^ ref_s3_q;

  always_ff @(posedge clk or posedge clr) begin
    if (clr) begin
      idle_q <= 16'h0000;
    end else if (ref_edge) begin
      idle_q <= 16'h0000;
    end else if (idle_q != 16'hffff) begin
      idle_q <= idle_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge clr) begin
    if (clr) begin
      trim <= 8'h00;
    end else if (ref_edge) begin
      trim <= trim + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  // Sequence restarts from reset.
  always_ff @(posedge clk or posedge clr) begin
    if (clr) begin
      state_q <= CAL_RUN;
      lat_q <= 16'h0000;
    end else begin
      case (state_q)
        CAL_RUN: begin
          if (idle_q >= 16'(REF_PERIOD_CYC)) begin
            lat_q <= 16'h0000;
          end else if (lat_q == 16'(CAL_LAT_CYC - 1)) begin
            state_q <= CAL_DONE;
          end else begin
            lat_q <= lat_q + 16'h0001;
          end
        end
        CAL_DONE: begin
          if (idle_q >= 16'(REF_PERIOD_CYC)) begin
            state_q <= CAL_LOST;
          end
        end
        CAL_LOST: state_q <= CAL_LOST;
        default: state_q <= CAL_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or posedge clr) begin
    if (clr) begin
      ready <= 1'b0;
    end else begin
      ready <= (state_q == CAL_DONE) &&
               (idle_q < 16'(REF_PERIOD_CYC - 1));
    end
  end

endmodule

/* File: src/dlc_delay_end.sv */
// Purpose: Programmable delay lines with region calibrators.
// Assumes: Step controls arrive synchronous to CLK.
// Notes: Each line is a 64-stage tapped shift register.
`timescale 1ns/10ps
module dlc_delay_end
  import dlc_pkg::*;
#(
  parameter dlc_pkg::dlc_delay_type_e DELAY_TYPE = dlc_pkg::DLC_VARIABLE
)
(
  input wire logic CLK,
  input wire logic RESETN,
  dlc_if.device LNK,
  input wire logic [dlc_pkg::N_LINES-1:0] DATA_IN,
  output logic [dlc_pkg::N_LINES-1:0] DATA_OUT,
  output logic [dlc_pkg::N_LINES*dlc_pkg::TAP_W-1:0] TAP,
  output logic [dlc_pkg::N_REGIONS*8-1:0] TRIM
);
  import dlc_pkg::*;

  logic [N_REGIONS-1:0] region_rdy;
  logic rdy_q;
  logic [7:0] region_trim [N_REGIONS];

  // ----------------------------------------------------------------
  // Delay lines
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N_LINES; i++) begin : g_line
    logic [TAP_W-1:0] tap_q;
    logic [TAP_W-1:0] tap_d;
    logic [N_TAPS-1:0] chain_q;
    logic variable_mode;

    assign variable_mode = (DELAY_TYPE == DLC_VARIABLE);

    // Next tap value from reset, step and direction.
    always_comb begin
      tap_d = tap_q;
      if (LNK.tap_rst[i]) begin
        tap_d = PRESET_TAP_VALUE;
      end else if (LNK.step_en[i] && variable_mode) begin
        if (LNK.step_up[i]) begin
          if (tap_q == TAP_MAX) begin
            tap_d = TAP_MIN;
          end else begin
            tap_d = tap_q + 6'h01;
          end
        end else begin
          if (tap_q == TAP_MIN) begin
            tap_d = TAP_MAX;
          end else begin
            tap_d = tap_q - 6'h01;
          end
        end
      end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        tap_q <= PRESET_TAP_VALUE;
      end else begin
        tap_q <= tap_d;
      end
    end

    // The chain runs every cycle so a tap change never loses history.
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        chain_q <= '0;
      end else begin
        chain_q <= {chain_q[N_TAPS-2:0], DATA_IN[i]};
      end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        DATA_OUT[i] <= 1'b0;
      end else begin
        DATA_OUT[i] <= chain_q[tap_q];
      end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        TAP[i*TAP_W +: TAP_W] <= PRESET_TAP_VALUE;
      end else begin
        TAP[i*TAP_W +: TAP_W] <= tap_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Region calibrators
  // ----------------------------------------------------------------
  // Calibrators always present.
  for (genvar r = 0; r < N_REGIONS; r++) begin : g_region
    dlc_delay_calibrator u_cal (
      .clk(CLK),
      .resetn(RESETN),
      .cal_rst(LNK.cal_rst),
      .ref_lvl(LNK.calibration_reference_clock),
      .ready(region_rdy[r]),
      .trim(region_trim[r])
    );

    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        TRIM[r*8 +: 8] <= 8'h00;
      end else begin
        TRIM[r*8 +: 8] <= region_trim[r];
      end
    end
  end

  // ----------------------------------------------------------------
  // Combined ready
  // ----------------------------------------------------------------
  // A registered AND keeps the link output glitch free; it costs one
  // cycle of latency on both rise and fall.
  // AND of region ready.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdy_q <= 1'b0;
    end else if (LNK.cal_rst) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= &region_rdy;
    end
  end

  assign LNK.cal_ready = rdy_q;

endmodule

/* File: src/dlc_if.sv */
// Purpose: Link between user control logic and the delay lines.
// Assumes: All signals change on the rising edge of the shared clock.
// Notes: The reference clock is a divided level, not a clock net.
`timescale 1ns/10ps
interface dlc_if;
  import dlc_pkg::*;
  logic [N_LINES-1:0] step_en;
  logic [N_LINES-1:0] step_up;
  logic [N_LINES-1:0] tap_rst;
  logic cal_rst;
  logic calibration_reference_clock;
  logic cal_ready;

  modport device (
    input step_en,
    input step_up,
    input tap_rst,
    input cal_rst,
    input calibration_reference_clock,
    output cal_ready
  );

  modport user (
    output step_en,
    output step_up,
    output tap_rst,
    output cal_rst,
    output calibration_reference_clock,
    input cal_ready
  );
endinterface

/* File: src/dlc_pkg.sv */
// Purpose: Shared constants for the delay line control link.
// Assumes: One 100 MHz clock for both ends.
// Notes: Summary of operation below.
//
// Summary of operation
// - Tap changes only on sampled step enable; the code also loads it on sampled tap reset.
// - Direction high at step means increment.
// - Enabled step moves exactly one tap.
// - Tap reset loads preset tap next edge.
// - Tap counter wraps between 63 and 0.
// - Tap reset beats step enable, direction.
// - Calibrator required for fixed, variable lines.
// - Calibrator keeps calibrating against reference clock.
// - Calibrator reset active high, asynchronous.
// - User pulses calibrator reset after startup.
// - Reset transition starts new calibration sequence.
// - Ready rises after calibration startup latency.
// - Ready falls on stalled reference clock.
// - User resets calibrator when ready lost.
// - One calibrator serves each clock region.
// - Replicas share reset and reference clock.
// - Visible ready is AND over regions.
// - Ready may be left unused.
// - Step controls synchronous to control clock.
package dlc_pkg;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int N_LINES = 4;
  localparam int N_REGIONS = 2;
  localparam int LINES_PER_REGION = N_LINES / N_REGIONS;
  localparam int TAP_W = 6;
  localparam int N_TAPS = 64;
  localparam logic [TAP_W-1:0] TAP_MAX = 6'h3f;
  localparam logic [TAP_W-1:0] TAP_MIN = 6'h00;
  localparam logic [TAP_W-1:0] PRESET_TAP_VALUE = 6'h00;

  typedef enum {DLC_FIXED, DLC_VARIABLE} dlc_delay_type_e;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int REF_PERIOD_NS = 40;
  localparam int REF_HALF_CYC = REF_PERIOD_NS / (2 * CLK_NS);
  localparam int REF_PERIOD_CYC = REF_PERIOD_NS / CLK_NS;
  localparam int CAL_LAT_NS = 1000;
  localparam int CAL_LAT_CYC = CAL_LAT_NS / CLK_NS;
  localparam int CAL_RST_NS = 50;
  localparam int CAL_RST_CYC = (CAL_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int REF_SETTLE_NS = 200;
  localparam int REF_SETTLE_CYC = REF_SETTLE_NS / CLK_NS;

  // ----------------------------------------------------------------
  // Registers of the user end
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] CMD_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  localparam int CTRL_REF_RUN = 0;
  localparam int CTRL_AUTO_RECAL = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int CMD_MASK_LSB = 0;
  localparam int CMD_UP = 4;
  localparam int CMD_STEP = 5;
  localparam int CMD_TAP_RST = 6;
  localparam int CMD_CAL_RST = 7;
  localparam int STAT_READY = 0;
  localparam int STAT_CAL_RST = 1;
  localparam int STAT_LOST = 2;

endpackage

/* File: src/dlc_user_end.sv */
// Purpose: User logic driving delay steps and calibrator reset.
// Assumes: Avalon-MM master holds requests until waitrequest low.
// Notes: Makes the reference clock by dividing CLK.
`timescale 1ns/10ps
module dlc_user_end
  import dlc_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  dlc_if.user LNK,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);
  import dlc_pkg::*;

  logic [1:0] ctrl_q;
  logic lost_q;
  logic rdy_seen_q;
  logic req;
  logic wr_go;
  logic [7:0] wb;
  logic [7:0] rst_cnt_q;
  logic [7:0] settle_q;
  logic [7:0] div_q;
  logic ref_q;
  logic rst_q;
  logic kick;
  logic [N_LINES-1:0] en_q;
  logic [N_LINES-1:0] up_q;
  logic [N_LINES-1:0] trst_q;

  // ----------------------------------------------------------------
  // Avalon slave
  // ----------------------------------------------------------------
  assign req = AVS_READ | AVS_WRITE;
  assign wr_go = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
  assign wb = AVS_WRITEDATA[7:0];

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      AVS_READDATA <= 32'h00000000;
    end else if (AVS_READ & AVS_WAITREQUEST) begin
      case (AVS_ADDRESS)
        CTRL_OFS: AVS_READDATA <= {30'h0, ctrl_q};
        STAT_OFS: AVS_READDATA <= {29'h0, lost_q, rst_q, LNK.cal_ready};
        default: AVS_READDATA <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_go && AVS_ADDRESS == CTRL_OFS) begin
      ctrl_q <= wb[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Tap steps
  // ----------------------------------------------------------------
  // Controls driven from CLK flops.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      en_q <= '0;
      up_q <= '0;
      trst_q <= '0;
    end else if (wr_go && AVS_ADDRESS == CMD_OFS) begin
      en_q <= wb[CMD_STEP] ? wb[CMD_MASK_LSB +: N_LINES] : '0;
      up_q <= wb[CMD_UP] ? wb[CMD_MASK_LSB +: N_LINES] : '0;
      trst_q <= wb[CMD_TAP_RST] ? wb[CMD_MASK_LSB +: N_LINES] : '0;
    end else begin
      en_q <= '0;
      trst_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Reference clock and calibrator reset
  // ----------------------------------------------------------------
  // Divided reference while enabled.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_q <= 8'h00;
      ref_q <= 1'b0;
    end else if (ctrl_q[CTRL_REF_RUN]) begin
      if (div_q == 8'(REF_HALF_CYC - 1)) begin
        div_q <= 8'h00;
        ref_q <= ~ref_q;
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end

  assign kick = (settle_q == 8'(REF_SETTLE_CYC - 1)) ||
                (wr_go && AVS_ADDRESS == CMD_OFS && wb[CMD_CAL_RST]) ||
                (ctrl_q[CTRL_AUTO_RECAL] && rdy_seen_q && !LNK.cal_ready);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      settle_q <= 8'h00;
    end else if (settle_q != 8'(REF_SETTLE_CYC)) begin
      settle_q <= settle_q + 8'h01;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_cnt_q <= 8'h00;
      rst_q <= 1'b0;
    end else if (kick) begin
      rst_cnt_q <= 8'(CAL_RST_CYC - 1);
      rst_q <= 1'b1;
    end else if (rst_cnt_q != 8'h00) begin
      rst_cnt_q <= rst_cnt_q - 8'h01;
    end else begin
      rst_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdy_seen_q <= 1'b0;
      lost_q <= 1'b0;
    end else begin
      // Ready still lags one cycle behind a new reset pulse, so it must
      // not count as seen then or the pulse would be kicked twice.
      rdy_seen_q <= kick ? 1'b0 : (rdy_seen_q | (LNK.cal_ready & ~rst_q));
      if (rdy_seen_q && !LNK.cal_ready) begin
        lost_q <= 1'b1;
      end else if (wr_go && AVS_ADDRESS == STAT_OFS && wb[STAT_LOST]) begin
        lost_q <= 1'b0;
      end
    end
  end

  assign LNK.step_en = en_q;
  assign LNK.step_up = up_q;
  assign LNK.tap_rst = trst_q;
  assign LNK.cal_rst = rst_q;
  assign LNK.calibration_reference_clock = ref_q;

endmodule

/* File: test/dlc_link_chk.sv */
// Purpose: Assertions on the link between the user end and the delay end.
// Assumes: One clock; RESETN asynchronous, active low.
// Notes: Latency bounds leave room for the ready synchroniser.
`timescale 1ns/10ps
module dlc_link_chk
  import dlc_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [dlc_pkg::N_LINES-1:0] step_en,
  input wire logic [dlc_pkg::N_LINES-1:0] step_up,
  input wire logic [dlc_pkg::N_LINES-1:0] tap_rst,
  input wire logic cal_rst,
  input wire logic calibration_reference_clock,
  input wire logic cal_ready
);
  localparam int LAT_LO = 100;
  localparam int LAT_HI = 120;
  logic [7:0] since_q;
  logic [3:0] still_q;
  logic ref_q;
  logic stall_q;

  // ----
  // Helper counters
  // ----
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      since_q <= 8'h00;
    end else if (cal_rst) begin
      since_q <= 8'h00;
    end else if (since_q != 8'hff) begin
      since_q <= since_q + 8'h01;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ref_q <= 1'b0;
      still_q <= 4'h0;
    end else begin
      ref_q <= calibration_reference_clock;
      if (ref_q != calibration_reference_clock) begin
        still_q <= 4'h0;
      end else if (still_q != 4'hf) begin
        still_q <= still_q + 4'h1;
      end
    end
  end

  // A stall clears only on a new calibration, since ready stays lost.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      stall_q <= 1'b0;
    end else if (cal_rst) begin
      stall_q <= 1'b0;
    end else if (still_q >= 4'h3) begin
      stall_q <= 1'b1;
    end
  end

  // ----
  // Assertions
  // ----
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  chk_ready_in_rst: assert property (cal_rst |=> !cal_ready)
    else $error("ready high during calibrator reset");
  chk_rst_width: assert property (
    $rose(cal_rst) |-> cal_rst [*5] ##1 !cal_rst)
    else $error("calibrator reset pulse width wrong");
  chk_ready_early: assert property (
    $rose(cal_ready) |-> since_q >= LAT_LO)
    else $error("ready rose before calibration latency");
  chk_ready_late: assert property (
    (since_q == LAT_HI && !stall_q) |-> cal_ready)
    else $error("ready missing after calibration latency");
  chk_ready_stall: assert property (still_q >= 4'ha |-> !cal_ready)
    else $error("ready high with stalled reference");
  chk_recal_lost: assert property (
    $fell(cal_ready) && !cal_rst |-> ##[1:40] cal_rst)
    else $error("no calibrator reset after ready lost");
  chk_ref_shape: assert property (
    $changed(calibration_reference_clock) |=>
    $stable(calibration_reference_clock))
    else $error("reference level shorter than two cycles");
  chk_step_pulse: assert property (
    step_en != '0 |=> step_en == '0)
    else $error("step enable longer than one cycle");
  chk_tap_pulse: assert property (
    tap_rst != '0 |=> tap_rst == '0)
    else $error("tap reset longer than one cycle");

  cover property ($rose(cal_ready));
  cover property (still_q >= 4'ha);
  cover property (step_en != '0 && tap_rst != '0);
  cover property ($fell(cal_ready) && !cal_rst);
endmodule

/* File: test/tb.sv */
// Purpose: Self-checking bench for the user end facing the delay end.
// Assumes: Avalon master holds each request until waitrequest is low.
// Notes: Ordinary tap commands are table rows; calibration is by hand.
`timescale 1ns/10ps
module tb;
  import dlc_pkg::*;
  typedef struct packed {
    logic trst;
    logic step;
    logic up;
    logic [3:0] mask;
  } dlc_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [N_LINES-1:0] data_in = '0;
  logic [N_LINES-1:0] data_out;
  logic [N_LINES*TAP_W-1:0] tap;
  logic [N_REGIONS*8-1:0] trim;
  logic [TAP_W-1:0] model [N_LINES];
  int errors = 0;
  int n_tests = 0;
  dlc_row_s rows [12] = '{7'h31, 7'h33, 7'h22, 7'h22, 7'h32, 7'h24,
                          7'h34, 7'h71, 7'h1f, 7'h28, 7'h48, 7'h3f};

  always #5 clk = ~clk;

  dlc_if lnk();
  dlc_user_end i_dlc_user_end (.CLK(clk), .RESETN(rst_n), .LNK(lnk.user),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest));
  dlc_delay_end #(.DELAY_TYPE(DLC_VARIABLE)) i_dlc_delay_end (.CLK(clk),
    .RESETN(rst_n), .LNK(lnk.device), .DATA_IN(data_in),
    .DATA_OUT(data_out), .TAP(tap), .TRIM(trim));
  dlc_link_chk i_dlc_link_chk (.CLK(clk), .RESETN(rst_n),
    .step_en(lnk.step_en), .step_up(lnk.step_up), .tap_rst(lnk.tap_rst),
    .cal_rst(lnk.cal_rst), .cal_ready(lnk.cal_ready),
    .calibration_reference_clock(lnk.calibration_reference_clock));

  // ----
  // Tasks
  // ----
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_tap(input logic [N_LINES*TAP_W-1:0] got);
    n_tests++;
    if (got !== {model[3], model[2], model[1], model[0]}) begin
      errors++;
      $display("mismatch at %0t: taps %h", $time, got);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // The request stands until waitrequest is seen low at a rising edge.
  task automatic bus_req(input logic wr, input logic [3:0] a,
      input logic [31:0] wd, input logic [3:0] be, output logic [31:0] rd);
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      $display("mismatch at %0t: bus request timed out", $time);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [31:0] wd,
      input logic [3:0] be = 4'hf);
    logic [31:0] rd;
    bus_req(1'b1, a, wd, be, rd);
  endtask

  task automatic bus_read(input logic [3:0] a, output logic [31:0] rd);
    bus_req(1'b0, a, 32'h0, 4'hf, rd);
  endtask

  task automatic wait_ready();
    logic [31:0] d = 32'h0;
    int n = 0;
    while (d[STAT_READY] !== 1'b1 && n < 100) begin
      bus_read(STAT_OFS, d);
      n++;
    end
    cmp_word(d & 32'h1, 32'h1); // Ready seen.
  endtask

  task automatic measure(output int lat);
    @(posedge clk);
    data_in <= 4'h1;
    @(posedge clk);
    data_in <= 4'h0;
    lat = 0;
    while (data_out[0] !== 1'b1 && lat < 200) begin
      @(posedge clk);
      lat++;
    end
  endtask

  // ----
  // Sequence
  // ----
  initial begin
    logic [31:0] d;
    logic [15:0] t0;
    int lat0;
    int lat1;
    foreach (model[i]) model[i] = PRESET_TAP_VALUE;
    repeat (2) @(posedge clk);
    cmp_tap(tap); // Preset taps in reset.
    cmp_word({31'h0, lnk.cal_ready}, 32'h0); // Ready low in reset.
    rst_n <= 1'b1;
    wait_ready();
    for (int r = 0; r < 12; r++) begin
      for (int i = 0; i < N_LINES; i++) begin
        if (rows[r].mask[i] && rows[r].trst) begin
          model[i] = PRESET_TAP_VALUE;
        end else if (rows[r].mask[i] && rows[r].step) begin
          model[i] = rows[r].up ? model[i] + 6'h01 : model[i] - 6'h01;
        end
      end
      bus_write(CMD_OFS, {25'h0, rows[r]});
      repeat (2) @(posedge clk);
      cmp_tap(tap); // Row taps.
    end
    bus_write(CMD_OFS, 32'h31, 4'he);
    repeat (2) @(posedge clk);
    cmp_tap(tap); // Step without lane 0 ignored.
    bus_write(4'hc, 32'hffffffff);
    bus_read(4'hc, d);
    cmp_word(d, 32'h0); // Unmapped place reads zero.
    measure(lat0);
    bus_write(CMD_OFS, 32'h31);
    repeat (2) @(posedge clk);
    measure(lat1);
    cmp_word(32'(lat1), 32'(lat0 + 1)); // One tap more delay.
    t0 = trim;
    repeat (20) @(posedge clk);
    cmp_word({30'h0, trim[15:8] !== t0[15:8], trim[7:0] !== t0[7:0]},
             32'h3); // Both regions calibrate.
    bus_write(CTRL_OFS, 32'h2);
    bus_read(CTRL_OFS, d);
    cmp_word(d, 32'h2); // Control reads back.
    repeat (20) @(posedge clk);
    bus_read(STAT_OFS, d);
    cmp_word(d & 32'h5, 32'h4); // Ready lost on stall.
    bus_write(CTRL_OFS, 32'h3);
    bus_write(STAT_OFS, 32'h4);
    bus_read(STAT_OFS, d);
    cmp_word(d & 32'h4, 32'h0); // Lost flag cleared by write.
    bus_write(CMD_OFS, 32'h80);
    wait_ready();
    bus_write(CMD_OFS, 32'h80);
    bus_read(STAT_OFS, d);
    cmp_word(d & 32'h7, 32'h2); // Reset drops ready.
    wait_ready();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    foreach (model[i]) model[i] = PRESET_TAP_VALUE;
    cmp_tap(tap); // Taps preset by reset.
    cmp_word({31'h0, lnk.cal_ready}, 32'h0); // Ready low in reset.
    rst_n <= 1'b1;
    wait_ready();
    give_verdict();
  end

  initial begin
    #100000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
